// File: core/uart_line_ctrl.sv
`timescale 1ns/1ps
// Overview of operation
// R01: hold received ninth bit; transmit ninth writable
// R02: single-line: direction bit selects txd output/input
// R03: txd inversion bit inverts transmitted levels
// R04: rxd inversion bit inverts sampled receive level
// R05: standby idle flag only if idle-select set
// R06: idle count after stop or start bit
// R07: wake-select: address mark or idle line
// R08: break flag set; write one clears
// R09: rx edge flag set; write one clears
// R10: read-only receiver activity bit
// R11: break lasts 13 or 10 plus extras
// R12: detect break after low over 11 bits
// R13: loop bit joins transmit and receive paths
// R14: wake-up bit puts receiver in standby
// R15: read-only main status flags
// R16: interrupt on enabled break or edge flag
module uart_line_ctrl (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_bit_tick,
  input wire logic i_tx_level,
  input wire uart_line_pkg::rx_evt_t i_rx_evt,
  input wire logic [7:0] i_status_flags,
  input wire logic i_rxd,
  input wire logic i_txd,
  output logic o_txd,
  output logic o_txd_oe,
  output logic o_rx_level,
  output logic o_tx_ninth,
  output logic o_rx_standby,
  output logic o_break_active,
  output logic o_irq
);
  import uart_line_pkg::*;

  logic [1:0] rst_sync_q;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  wire rst_n = rst_sync_q[1];

  logic [7:0] ctrl1_q;
  logic [7:0] ctrl2_q;
  line_ctrl3_t ctrl3_q;
  logic [1:0] irq_en_q;
  logic [1:0] sync_cfg_q;
  logic brk_if_q;
  logic edge_if_q;
  logic idle_if_q;
  logic brk_gen_q;
  logic rx_level_q;
  logic rx_prev_q;
  logic idle_armed_q;
  logic [7:0] rdata_q;
  logic [CNT_W-1:0] brk_cnt;
  logic [CNT_W-1:0] det_cnt;
  logic [CNT_W-1:0] idle_cnt;
  logic rxd_sync;
  logic txd_sync;

  // address decode
  wire wr_ctrl1 = i_wr && (i_addr == ADDR_CTRL1);
  wire wr_ctrl2 = i_wr && (i_addr == ADDR_CTRL2);
  wire wr_ctrl3 = i_wr && (i_addr == ADDR_CTRL3);
  wire wr_sync = i_wr && (i_addr == ADDR_SYNC);
  wire wr_irq_en = i_wr && (i_addr == ADDR_IRQ_EN);
  wire rd_status = i_rd && (i_addr == ADDR_STATUS);

  wire loop_mode = ctrl1_q[BIT_LOOP];
  wire single_txd = ctrl1_q[BIT_SINGLE];
  wire data9 = ctrl1_q[BIT_DATA9];
  wire stop2 = ctrl1_q[BIT_STOP2];
  wire rwu = ctrl2_q[BIT_RWU];
  wire brk_size = sync_cfg_q[BIT_BRK_SIZE];
  wire brk_det_en = sync_cfg_q[BIT_BRK_DET_EN];

  // extra bit times for 9-bit data and two stop bits
  wire [CNT_W-1:0] extra = {4'b0000, data9} + {4'b0000, stop2};
  wire [CNT_W-1:0] brk_gen_len = (brk_size ? BRK_LONG_BITS : BRK_SHORT_BITS) + extra; // see R11
  wire [CNT_W-1:0] brk_det_len = BRK_DETECT_BITS + extra; // see R12
  wire [CNT_W-1:0] idle_len = IDLE_CHAR_BITS + extra; // see R06

  // break generation: a write that takes the send bit from 1 to 0
  wire brk_start = wr_ctrl2 && ctrl2_q[BIT_BRK_SEND] && !i_wdata[BIT_BRK_SEND] && !brk_gen_q;
  wire brk_end = brk_gen_q && i_bit_tick && (brk_cnt == brk_gen_len - 5'd1); // see R11

  bit_time_counter #(.W(CNT_W)) u_brk_gen_cnt (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_clear(!brk_gen_q),
    .i_tick(i_bit_tick),
    .o_count(brk_cnt)
  );

  // transmit side and pin direction
  wire tx_raw = brk_gen_q ? 1'b0 : i_tx_level;
  wire tx_pin_level = tx_raw ^ ctrl3_q.txd_inv; // see R03
  wire txd_oe_d = !loop_mode ? 1'b1 : (single_txd & ctrl3_q.txd_dir_out); // see R02

  pin_sync3 u_rxd_sync (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_pin(i_rxd),
    .o_level(rxd_sync)
  );

  pin_sync3 u_txd_sync (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_pin(i_txd),
    .o_level(txd_sync)
  );

  // receive source: pin, shared txd pin, or internal loop
  wire rx_src = !loop_mode ? rxd_sync : (single_txd ? txd_sync : tx_pin_level); // see R13
  wire rx_level_d = rx_src ^ ctrl3_q.rxd_inv; // see R04

  wire edge_evt = rx_prev_q && !rx_level_q;

  bit_time_counter #(.W(CNT_W)) u_brk_det_cnt (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_clear(rx_level_q || !brk_det_en),
    .i_tick(i_bit_tick),
    .o_count(det_cnt)
  );
  wire brk_evt = brk_det_en && !rx_level_q && i_bit_tick && (det_cnt == brk_det_len); // see R12

  // idle detection
  wire idle_arm = ctrl3_q.idle_after_stop ? i_rx_evt.stop : i_rx_evt.start; // see R06
  bit_time_counter #(.W(CNT_W)) u_idle_cnt (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_clear(!idle_armed_q || !rx_level_q),
    .i_tick(i_bit_tick),
    .o_count(idle_cnt)
  );
  wire idle_evt = idle_armed_q && rx_level_q && i_bit_tick && (idle_cnt == idle_len - 5'd1);
  wire idle_set = idle_evt && (!rwu || ctrl3_q.standby_idle_sel); // see R05
  wire wake_evt = rwu && (ctrl3_q.wake_addr_mark ? i_rx_evt.addr_mark : idle_evt); // see R07

  // flags: a set in the same cycle as a clear wins
  wire brk_if_d = brk_evt || (brk_if_q && !(wr_sync && i_wdata[BIT_BRK_IF])); // see R08
  wire edge_if_d = edge_evt || (edge_if_q && !(wr_sync && i_wdata[BIT_EDGE_IF])); // see R09
  wire idle_if_d = idle_set || (idle_if_q && !rd_status);

  // read selection
  wire [7:0] sync_rd = {brk_if_q, edge_if_q, i_rx_evt.active, 3'b000, sync_cfg_q}; // see R10
  wire [7:0] status_rd = {i_status_flags[7:5], idle_if_q, i_status_flags[3:0]}; // see R15
  wire [7:0] rd_sel =
    (i_addr == ADDR_IRQ_EN) ? {irq_en_q, 6'b00_0000} :
    (i_addr == ADDR_CTRL1) ? ctrl1_q :
    (i_addr == ADDR_CTRL2) ? ctrl2_q :
    (i_addr == ADDR_CTRL3) ? ctrl3_q :
    (i_addr == ADDR_SYNC) ? sync_rd :
    (i_addr == ADDR_STATUS) ? status_rd : RESET_BYTE;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl1_q <= RESET_BYTE;
      irq_en_q <= 2'b00;
      sync_cfg_q <= 2'b00;
    end else begin
      if (wr_ctrl1) begin
        ctrl1_q <= {i_wdata[7:4], 4'b0000};
      end
      if (wr_irq_en) begin
        irq_en_q <= i_wdata[BIT_BRK_IE:BIT_EDGE_IE];
      end
      if (wr_sync) begin
        sync_cfg_q <= i_wdata[1:0];
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl2_q <= RESET_BYTE;
    end else if (wr_ctrl2) begin
      ctrl2_q <= i_wdata; // see R14
    end else if (wake_evt) begin
      ctrl2_q[BIT_RWU] <= 1'b0; // see R14
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl3_q <= '0;
    end else begin
      if (wr_ctrl3) begin
        ctrl3_q[6:0] <= i_wdata[6:0];
      end
      if (i_rx_evt.done) begin
        ctrl3_q.receive_ninth_bit <= i_rx_evt.ninth; // see R01
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      brk_if_q <= 1'b0;
      edge_if_q <= 1'b0;
      idle_if_q <= 1'b0;
      brk_gen_q <= 1'b0;
    end else begin
      brk_if_q <= brk_if_d;
      edge_if_q <= edge_if_d;
      idle_if_q <= idle_if_d;
      brk_gen_q <= brk_start || (brk_gen_q && !brk_end);
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_level_q <= 1'b1;
      rx_prev_q <= 1'b1;
      idle_armed_q <= 1'b0;
      o_txd <= 1'b1;
      o_txd_oe <= 1'b0;
      rdata_q <= RESET_BYTE;
    end else begin
      rx_level_q <= rx_level_d;
      rx_prev_q <= rx_level_q;
      idle_armed_q <= idle_arm || (idle_armed_q && !idle_evt);
      o_txd <= tx_pin_level;
      o_txd_oe <= txd_oe_d;
      rdata_q <= i_rd ? rd_sel : RESET_BYTE;
    end
  end

  assign o_rdata = rdata_q;
  assign o_rx_level = rx_level_q;
  assign o_tx_ninth = ctrl3_q.transmit_ninth_bit; // see R01
  assign o_rx_standby = rwu;
  assign o_break_active = brk_gen_q;
  assign o_irq = (brk_if_q && irq_en_q[1]) || (edge_if_q && irq_en_q[0]); // see R16

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n);

  sequence s_brk_begin;
    brk_start;
  endsequence
  sequence s_brk_hold;
    o_break_active;
  endsequence

  // the pin shows the break level, after inversion, two cycles after brk_start
  property p_brk_low;
    s_brk_begin |=> s_brk_hold ##1 (o_txd == $past(ctrl3_q.txd_inv));
  endproperty
  a_brk_low: assert property (p_brk_low) else $error("break not held low"); // see R11

  property p_brk_len;
    $fell(brk_gen_q) |-> $past(brk_cnt) == brk_gen_len - 5'd1;
  endproperty
  a_brk_len: assert property (p_brk_len) else $error("break length wrong"); // see R11

  property p_txd_inv;
    1'b1 |=> o_txd == ($past(tx_raw) ^ $past(ctrl3_q.txd_inv));
  endproperty
  a_txd_inv: assert property (p_txd_inv) else $error("txd level wrong"); // see R03

  property p_txd_dir;
    (loop_mode && single_txd) |=> o_txd_oe == $past(ctrl3_q.txd_dir_out);
  endproperty
  a_txd_dir: assert property (p_txd_dir) else $error("txd direction wrong"); // see R02

  property p_edge_set;
    $fell(rx_level_q) |=> edge_if_q [*2];
  endproperty
  a_edge_set: assert property (p_edge_set) else $error("edge flag missed"); // see R09

  property p_brk_w0;
    (brk_if_q && wr_sync && !i_wdata[BIT_BRK_IF]) |=> brk_if_q;
  endproperty
  a_brk_w0: assert property (p_brk_w0) else $error("break flag cleared by 0"); // see R08

  property p_idle_standby;
    (idle_evt && rwu && !ctrl3_q.standby_idle_sel && !idle_if_q) |=> !idle_if_q;
  endproperty
  a_idle_standby: assert property (p_idle_standby) else $error("idle set in standby"); // see R05

  property p_wake_idle;
    (rwu && !ctrl3_q.wake_addr_mark && idle_evt && !wr_ctrl2) |=> !o_rx_standby;
  endproperty
  a_wake_idle: assert property (p_wake_idle) else $error("idle wake missed"); // see R07

  property p_ninth;
    i_rx_evt.done |=> ctrl3_q.receive_ninth_bit == $past(i_rx_evt.ninth);
  endproperty
  a_ninth: assert property (p_ninth) else $error("ninth bit not held"); // see R01

  property p_irq;
    (edge_if_q && irq_en_q[0]) |-> o_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing"); // see R16
endmodule // uart_line_ctrl

// File: include/uart_line_pkg.sv
package uart_line_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_IRQ_EN = 8'h00_c2;
  localparam logic [7:0] ADDR_CTRL1 = 8'h00_c4;
  localparam logic [7:0] ADDR_CTRL2 = 8'h00_c5;
  localparam logic [7:0] ADDR_CTRL3 = 8'h00_c6;
  localparam logic [7:0] ADDR_SYNC = 8'h00_c7;
  localparam logic [7:0] ADDR_STATUS = 8'h00_c8;

  // bit positions
  localparam int BIT_BRK_IE = 7;
  localparam int BIT_EDGE_IE = 6;
  localparam int BIT_LOOP = 7;
  localparam int BIT_STOP2 = 6;
  localparam int BIT_SINGLE = 5;
  localparam int BIT_DATA9 = 4;
  localparam int BIT_RX_EN = 2;
  localparam int BIT_RWU = 1;
  localparam int BIT_BRK_SEND = 0;
  localparam int BIT_BRK_IF = 7;
  localparam int BIT_EDGE_IF = 6;
  localparam int BIT_RX_ACTIVE = 5;
  localparam int BIT_BRK_SIZE = 1;
  localparam int BIT_BRK_DET_EN = 0;
  localparam int BIT_IDLE_IF = 4;

  localparam logic [7:0] RESET_BYTE = 8'h00_00;

  // lengths in bit times
  localparam logic [4:0] BRK_LONG_BITS = 5'd13;
  localparam logic [4:0] BRK_SHORT_BITS = 5'd10;
  localparam logic [4:0] BRK_DETECT_BITS = 5'd11;
  localparam logic [4:0] IDLE_CHAR_BITS = 5'd10;
  localparam int CNT_W = 5;

  typedef struct packed {
    logic receive_ninth_bit;
    logic transmit_ninth_bit;
    logic txd_dir_out;
    logic txd_inv;
    logic rxd_inv;
    logic standby_idle_sel;
    logic idle_after_stop;
    logic wake_addr_mark;
  } line_ctrl3_t;

  typedef struct packed {
    logic start;
    logic stop;
    logic done;
    logic ninth;
    logic addr_mark;
    logic active;
  } rx_evt_t;

endpackage

// File: core/pin_sync3.sv
`timescale 1ns/1ps
module pin_sync3 (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_pin,
  output logic o_level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // change taken once stages two and three agree
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      o_level <= 1'b1;
    end else begin
      s1_q <= i_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        o_level <= s3_q;
      end
    end
  end
endmodule // pin_sync3

// File: core/bit_time_counter.sv
`timescale 1ns/1ps
module bit_time_counter #(
  parameter int W = 5
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_clear,
  input wire logic i_tick,
  output logic [W-1:0] o_count
);
  initial begin
    if (W < 4) begin
      $error("bit_time_counter: W too small");
    end
  end

  wire at_max = &o_count;

  // saturating count of bit ticks
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_count <= '0;
    end else if (i_clear) begin
      o_count <= '0;
    end else if (i_tick && !at_max) begin
      o_count <= o_count + W'(1);
    end
  end
endmodule // bit_time_counter

// File: tb/uart_remote_peer.sv
`timescale 1ns/1ps
module uart_remote_peer (
  input wire logic i_clk,
  input wire logic i_bit_tick,
  output logic o_rxd
);
  // the line idles high between frames; holding it low models a break
  initial o_rxd = 1'b1;
  task automatic hold_low(input int ticks);
    int n;
    n = 0;
    @(posedge i_clk) o_rxd <= 1'b0;
    while (n < ticks) begin
      @(posedge i_clk);
      if (i_bit_tick) n++;
    end
    o_rxd <= 1'b1;
  endtask
endmodule // uart_remote_peer

// File: tb/uart_line_ctrl_bench.sv
`timescale 1ns/1ps
module uart_line_ctrl_bench;
  import uart_line_pkg::*;
  logic i_clk = 1'b0, i_nrst = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_bit_tick = 1'b0;
  logic i_tx_level = 1'b1;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, i_status_flags = 8'h00, o_rdata, d;
  rx_evt_t i_rx_evt = '0;
  logic o_txd, o_txd_oe, o_rx_level, o_tx_ninth, o_rx_standby, o_break_active, o_irq;
  logic rxd, txd;
  logic [1:0] div = 2'h0;
  logic [31:0] seed = 32'h0519_df93;
  int mismatches = 0, total_checks = 0, n, k, len;
  always #2.5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    div <= div + 2'h1;
    i_bit_tick <= (div == 2'h3);
  end
  // txd pin is pulled up when nobody drives it
  assign txd = o_txd_oe ? o_txd : 1'b1;
  uart_remote_peer peer (.i_clk(i_clk), .i_bit_tick(i_bit_tick), .o_rxd(rxd));
  uart_line_ctrl dut (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_bit_tick(i_bit_tick), .i_tx_level(i_tx_level),
    .i_rx_evt(i_rx_evt), .i_status_flags(i_status_flags), .i_rxd(rxd), .i_txd(txd),
    .o_txd(o_txd), .o_txd_oe(o_txd_oe), .o_rx_level(o_rx_level), .o_tx_ninth(o_tx_ninth),
    .o_rx_standby(o_rx_standby), .o_break_active(o_break_active), .o_irq(o_irq)
  );
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, exp);
  endtask
  task automatic settle(input int c);
    repeat (c) @(posedge i_clk);
    #1;
  endtask
  task automatic pulse(input logic [5:0] v);
    @(posedge i_clk) i_rx_evt <= v;
    @(posedge i_clk) i_rx_evt <= '0;
    settle(3);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (3) @(posedge i_clk);
    rd(ADDR_CTRL3, 8'h00);
    rd(ADDR_SYNC, 8'h00);
    rd(8'h01, 8'h00);
    for (k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      wr(ADDR_CTRL3, seed[7:0]);
      rd(ADDR_CTRL3, seed[7:0] & 8'h7f);
      chk(o_tx_ninth, seed[6]);
    end
    pulse(6'h0c);
    rd(ADDR_CTRL3, (seed[7:0] & 8'h7f) | 8'h80);
    for (k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      wr(ADDR_CTRL3, k[0] ? 8'h10 : 8'h00);
      @(posedge i_clk) i_tx_level <= seed[0];
      settle(3);
      chk(o_txd, seed[0] ^ k[0]);
    end
    @(posedge i_clk) i_tx_level <= 1'b1;
    wr(ADDR_CTRL1, 8'ha0);
    for (k = 1; k >= 0; k--) begin
      wr(ADDR_CTRL3, k[0] ? 8'h20 : 8'h00);
      settle(2);
      chk(o_txd_oe, k[0]);
    end
    wr(ADDR_CTRL1, 8'h00);
    wr(ADDR_CTRL3, 8'h08);
    settle(8);
    chk(o_rx_level, 1'b0);
    wr(ADDR_CTRL3, 8'h00);
    settle(8);
    chk(o_rx_level, 1'b1);
    wr(ADDR_SYNC, 8'hc0);
    rd(ADDR_SYNC, 8'h00);
    wr(ADDR_IRQ_EN, 8'h40);
    peer.hold_low(2);
    settle(8);
    rd(ADDR_SYNC, 8'h40);
    chk(o_irq, 1'b1);
    wr(ADDR_SYNC, 8'h00);
    rd(ADDR_SYNC, 8'h40);
    wr(ADDR_SYNC, 8'h40);
    rd(ADDR_SYNC, 8'h00);
    chk(o_irq, 1'b0);
    wr(ADDR_IRQ_EN, 8'h80);
    wr(ADDR_SYNC, 8'h01);
    peer.hold_low(13);
    settle(8);
    rd(ADDR_SYNC, 8'hc1);
    chk(o_irq, 1'b1);
    wr(ADDR_SYNC, 8'hc1);
    rd(ADDR_SYNC, 8'h01);
    peer.hold_low(9);
    settle(8);
    @(posedge i_clk) i_rx_evt <= 6'h01;
    rd(ADDR_SYNC, 8'h61);
    chk(o_irq, 1'b0);
    @(posedge i_clk) i_rx_evt <= '0;
    wr(ADDR_SYNC, 8'hc0);
    for (k = 0; k < 3; k++) begin
      wr(ADDR_CTRL1, k == 0 ? 8'h00 : (k == 1 ? 8'h10 : 8'h50));
      wr(ADDR_SYNC, k == 0 ? 8'h00 : 8'h02);
      len = (k == 0 ? 10 : 13) + (k > 0) + (k == 2);
      wr(ADDR_CTRL2, 8'h01);
      wr(ADDR_CTRL2, 8'h00);
      n = 0;
      for (int c = 0; c < 400 && (n == 0 || o_break_active); c++) begin
        @(negedge i_clk);
        if (o_break_active && i_bit_tick) n++;
        if (n == 2 && i_bit_tick) chk(o_txd, 8'h00);
      end
      if (o_break_active) begin
        mismatches++;
        $display("ERROR t=%0t break did not end", $time);
      end
      chk(n[7:0], len[7:0]);
    end
    wr(ADDR_CTRL1, 8'h00);
    for (k = 1; k >= 0; k--) begin
      wr(ADDR_CTRL3, k[0] ? 8'h01 : 8'h00);
      wr(ADDR_CTRL2, 8'h02);
      settle(2);
      chk(o_rx_standby, 1'b1);
      pulse(6'h02);
      chk(o_rx_standby, !k[0]);
    end
    // idle wake leaves standby; idle-select clear, so no idle flag
    pulse(6'h20);
    settle(60);
    chk(o_rx_standby, 8'h00);
    rd(ADDR_STATUS, 8'h00);
    pulse(6'h20);
    settle(60);
    rd(ADDR_STATUS, 8'h10);
    rd(ADDR_STATUS, 8'h00);
    wr(ADDR_CTRL3, 8'h04);
    wr(ADDR_CTRL2, 8'h02);
    pulse(6'h20);
    settle(60);
    rd(ADDR_STATUS, 8'h10);
    chk(o_rx_standby, 8'h00);
    wr(ADDR_CTRL3, 8'h02);
    pulse(6'h20);
    settle(60);
    rd(ADDR_STATUS, 8'h00);
    pulse(6'h10);
    settle(60);
    rd(ADDR_STATUS, 8'h10);
    for (k = 0; k < 3; k++) begin
      seed = lfsr(seed);
      d = seed[7:0] & 8'hef;
      @(posedge i_clk) i_status_flags <= d;
      rd(ADDR_STATUS, d);
    end
    complete_run();
  end
endmodule // uart_line_ctrl_bench
